// ==== prm_pkg.sv ====
// Shared constants for the RMII pin block: register map, fields, timing
`default_nettype none
package prm_pkg;
  // Register indices on the register port
  localparam logic [4:0] REG_INT_CS = 5'h1b;
  localparam logic [4:0] REG_CTRL_TWO = 5'h1f;
  // Field positions in the control-two register
  localparam int CTRL2_INT_POL_BIT = 9;
  localparam int CTRL2_REF50_BIT = 7;
  localparam int CTRL2_WAKE_SEL_BIT = 3;
  localparam int CTRL2_WAKE_PEND_BIT = 0;
  // Field positions in the interrupt control/status register
  localparam int INT_EN_LSB = 8;
  localparam int INT_EV_W = 8;
  // Reset values of control fields
  localparam logic INT_POL_RESET = 1'b0;
  localparam logic WAKE_SEL_RESET = 1'b0;
  // Clock and timing
  localparam int SYS_PERIOD_NS = 40;
  localparam int REF_HALF_NS = 160;
  localparam int REF_HALF_CYC = REF_HALF_NS / SYS_PERIOD_NS;
  localparam int STRAP_SETTLE_NS = 200;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Receive buffer shape: one word is {error, dibit}
  localparam int RX_WORD_W = 3;
  localparam int RX_FIFO_DEPTH = 16;
  localparam int RX_ERR_BIT = 2;
  // Pin synchroniser lanes
  localparam int PIN_W = 7;
  localparam int PIN_EXT = 0;
  localparam int PIN_CRS = 1;
  localparam int PIN_RXER = 2;
  localparam int PIN_TXEN = 3;
  localparam int PIN_TXD0 = 4;
  localparam int PIN_TXD1 = 5;
  localparam int PIN_NAND = 6;
endpackage
`default_nettype wire

// ==== prm_fifo_if.sv ====
// Valid/ready carrier between the pin block and its receive buffer
`default_nettype none
interface prm_fifo_if #(parameter int W = 3);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport buffer (input wr_valid, input wr_data, input rd_ready,
                  output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface
`default_nettype wire

// ==== prm_sync.sv ====
// Two-flop synchroniser for pins from outside the system clock domain
`default_nettype none
module prm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== prm_fifo.sv ====
// Receive buffer: memory plus registered output stage
`default_nettype none
module prm_fifo #(
  parameter int W = 3,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Both sides
  prm_fifo_if.buffer f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic ov;
    logic [W-1:0] od;
  } prm_fifo_state_t;

  prm_fifo_state_t r, n;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pull;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin
      $error("prm_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  // Push when room, refill the output register when it empties or drains
  always_comb begin
    n = r;
    push = f.wr_valid && r.rdy;
    pull = (!r.ov || f.rd_ready) && (r.cnt != '0);
    if (push) begin
      n.wp = r.wp + AW'(1);
    end
    if (pull) begin
      n.od = mem[r.rp];
      n.rp = r.rp + AW'(1);
      n.ov = 1'b1;
    end else if (f.rd_ready) begin
      n.ov = 1'b0;
    end
    n.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pull);
    n.rdy = (n.cnt != FULL_CNT);
  end

  // State register; ready starts high on an empty buffer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{rdy: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // Storage has no reset, it is guarded by the count
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[r.wp] <= f.wr_data;
    end
  end

  assign f.wr_ready = r.rdy;
  assign f.rd_valid = r.ov;
  assign f.rd_data = r.od;
endmodule
`default_nettype wire

// ==== prm_rmii_pins.sv ====
// RMII pin side of the transceiver: data, reference clock, straps, interrupt
// Functional notes
// - RXD changes only on reference clock edges.
// - Each valid period carries two receive bits.
// - Take two TXD bits per TXEN period.
// - CRS_DV outputs carrier sense and data valid.
// - Latch CRS_DV level as address at release.
// - Strap pins are inputs until straps sampled.
// - 25MHz mode drives reference clock out.
// - 50MHz mode uses external clock input instead.
// - Control-two bit 7 selects reference mode.
// - Variant parameter picks power-up reference mode.
// - RXER pin outputs receive error indication.
// - Latch RXER level as wake enable strap.
// - Interrupt enables and status via register 1Bh.
// - Control-two bit 9 sets interrupt polarity.
// - Wake option pulls pin low on event.
// - Interrupt pin is open-drain, pulls low only.
// - NAND tree mode turns TXD1 into output.
// - External input takes 25MHz or 50MHz clock; the code reads it only in 50MHz mode, 25MHz mode divides sys_clk_i.
`default_nettype none
module prm_rmii_pins
  import prm_pkg::*;
#(
  parameter logic REF50_DEFAULT = 1'b0,
  parameter int REF_HALF = REF_HALF_CYC,
  parameter int STRAP_WAIT = STRAP_SETTLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Receive stream from the line side
  input wire logic rx_valid_i,
  input wire logic [1:0] rx_dibit_i,
  input wire logic rx_err_i,
  output logic rx_ready_o,
  // Transmit stream to the line side
  output logic tx_valid_o,
  output logic [1:0] tx_dibit_o,
  // Event sources
  input wire logic [INT_EV_W-1:0] int_event_i,
  input wire logic wake_on_lan_event_i,
  // Register port
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // Reference clock pins
  input wire logic external_clock_in_i,
  output logic ref_clk_o,
  output logic ref_clk_oe_o,
  // RMII pins
  output logic [1:0] rxd_o,
  output logic rxd_oe_o,
  input wire logic crs_dv_i,
  output logic crs_dv_o,
  output logic crs_dv_oe_o,
  input wire logic rxer_i,
  output logic rxer_o,
  output logic rxer_oe_o,
  input wire logic txen_i,
  input wire logic txd0_i,
  input wire logic txd1_i,
  output logic txd1_o,
  output logic txd1_oe_o,
  // Interrupt / wake-event pin, open-drain
  input wire logic interrupt_out_i,
  output logic interrupt_out_o,
  output logic interrupt_out_oe_o,
  // Test mode and strap results
  input wire logic nand_tree_mode_i,
  output logic [1:0] phy_address_strap_o,
  output logic wake_output_enable_strap_o,
  output logic ref_50m_mode_o
);
  typedef enum logic {PH_STRAP, PH_RUN} prm_phase_t;

  typedef struct packed {
    prm_phase_t phase;
    logic [7:0] wait_cnt;
    logic [7:0] div_cnt;
    logic ref_q;
    logic ext_q;
    logic pins_oe;
    logic ref_oe;
    logic [1:0] rxd;
    logic crs_dv;
    logic rxer;
    logic txd1;
    logic txd1_oe;
    logic int_drv;
    logic tx_valid;
    logic [1:0] tx_dibit;
    logic [1:0] phyad;
    logic wake_en;
    logic [INT_EV_W-1:0] int_en;
    logic [INT_EV_W-1:0] int_stat;
    logic int_pol;
    logic ref50;
    logic wake_sel;
    logic wake_pend;
    logic [15:0] rdata;
  } prm_state_t;

  localparam logic [7:0] REF_LAST = 8'(REF_HALF - 1);
  localparam logic [7:0] STRAP_LAST = 8'(STRAP_WAIT - 1);
  // Variant picks the power-up reference mode through REF50_DEFAULT
  localparam prm_state_t ST_RESET = '{phase: PH_STRAP, ref50: REF50_DEFAULT,
                                      int_pol: INT_POL_RESET, wake_sel: WAKE_SEL_RESET,
                                      default: '0};

  prm_state_t r, n;
  logic [PIN_W-1:0] pin_s;
  logic run;
  logic rise;
  logic active;
  logic wake_path;
  logic rd_ics;
  logic rd_c2;
  logic [INT_EV_W-1:0] ics_clr;

  initial begin
    if (REF_HALF < 1 || REF_HALF > 255 || STRAP_WAIT < 1 || STRAP_WAIT > 255) begin
      $error("prm_rmii_pins: REF_HALF and STRAP_WAIT must lie in 1..255");
    end
  end

  // Every pin from outside the system clock passes two flops first
  prm_sync #(
    .W(PIN_W)
  ) u_pin_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(reset_n_i),
    .d_i({nand_tree_mode_i, txd1_i, txd0_i, txen_i, rxer_i, crs_dv_i, external_clock_in_i}),
    .q_o(pin_s)
  );

  // Receive buffer between the line side and the RMII pins
  prm_fifo_if #(.W(RX_WORD_W)) rx_if ();

  prm_fifo #(
    .W(RX_WORD_W),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(sys_clk_i),
    .rst_n_i(reset_n_i),
    .f(rx_if.buffer)
  );

  assign rx_if.wr_valid = rx_valid_i;
  assign rx_if.wr_data = {rx_err_i, rx_dibit_i};
  assign rx_if.rd_ready = run && rise;

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    run = (r.phase == PH_RUN);
    n.tx_valid = 1'b0;
    // Free-running divider makes the 50MHz-equivalent reference in 25MHz mode
    if (r.div_cnt == REF_LAST) begin
      n.div_cnt = '0;
      n.ref_q = !r.ref_q;
    end else begin
      n.div_cnt = r.div_cnt + 8'h01;
    end
    n.ext_q = pin_s[PIN_EXT];
    // Rising edge from own divider, or from the external clock in 50MHz mode
    if (r.ref50) begin
      rise = pin_s[PIN_EXT] && !r.ext_q;
    end else begin
      rise = (r.div_cnt == REF_LAST) && !r.ref_q;
    end

    // Register decode; reads clear the status and pending bits they return
    rd_ics = reg_rd_i && (reg_addr_i == REG_INT_CS);
    rd_c2 = reg_rd_i && (reg_addr_i == REG_CTRL_TWO);
    ics_clr = rd_ics ? r.int_stat : '0;
    n.rdata = '0;
    if (rd_ics) begin
      n.rdata = {r.int_en, r.int_stat};
    end else if (rd_c2) begin
      n.rdata[CTRL2_INT_POL_BIT] = r.int_pol;
      n.rdata[CTRL2_REF50_BIT] = r.ref50;
      n.rdata[CTRL2_WAKE_SEL_BIT] = r.wake_sel;
      n.rdata[CTRL2_WAKE_PEND_BIT] = r.wake_pend;
    end
    if (reg_wr_i && reg_addr_i == REG_INT_CS) begin
      n.int_en = reg_wdata_i[INT_EN_LSB +: INT_EV_W];
    end
    if (reg_wr_i && reg_addr_i == REG_CTRL_TWO) begin
      n.int_pol = reg_wdata_i[CTRL2_INT_POL_BIT];
      n.ref50 = reg_wdata_i[CTRL2_REF50_BIT];
      n.wake_sel = reg_wdata_i[CTRL2_WAKE_SEL_BIT];
    end
    // New events win over a clearing read in the same cycle
    n.int_stat = (r.int_stat & ~ics_clr) | int_event_i;
    n.wake_pend = (r.wake_pend && !rd_c2) || wake_on_lan_event_i;

    case (r.phase)
      PH_STRAP: begin
        // Strap pins stay released while their levels settle through the syncs
        n.pins_oe = 1'b0;
        n.ref_oe = 1'b0;
        if (r.wait_cnt == STRAP_LAST) begin
          n.phyad = {2{pin_s[PIN_CRS]}};
          n.wake_en = pin_s[PIN_RXER];
          n.phase = PH_RUN;
          n.pins_oe = 1'b1;
        end else begin
          n.wait_cnt = r.wait_cnt + 8'h01;
        end
      end
      PH_RUN: begin
        n.ref_oe = !r.ref50;
        if (rise) begin
          // Outputs move and inputs are sampled on the same reference edge
          n.crs_dv = rx_if.rd_valid;
          n.rxd = rx_if.rd_valid ? rx_if.rd_data[1:0] : 2'b00;
          n.rxer = rx_if.rd_valid && rx_if.rd_data[RX_ERR_BIT];
          if (pin_s[PIN_TXEN]) begin
            n.tx_valid = 1'b1;
            n.tx_dibit = {pin_s[PIN_TXD1], pin_s[PIN_TXD0]};
          end
        end
      end
      default: begin
        n.phase = PH_STRAP;
      end
    endcase

    // NAND tree result replaces the TXD1 input
    n.txd1_oe = run && pin_s[PIN_NAND];
    n.txd1 = !(pin_s[PIN_TXEN] && pin_s[PIN_TXD0]);

    // Pin pulls low only: wake option, or interrupt at chosen polarity
    active = |(r.int_stat & r.int_en);
    wake_path = r.wake_en && r.wake_sel;
    if (wake_path) begin
      n.int_drv = run && r.wake_pend;
    end else begin
      n.int_drv = run && (active ^ r.int_pol);
    end
  end

  // One register for all block state
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state flops, except interrupt_out_o, which is tied low
  assign rx_ready_o = rx_if.wr_ready;
  assign tx_valid_o = r.tx_valid;
  assign tx_dibit_o = r.tx_dibit;
  assign reg_rdata_o = r.rdata;
  assign ref_clk_o = r.ref_q;
  assign ref_clk_oe_o = r.ref_oe;
  assign rxd_o = r.rxd;
  assign rxd_oe_o = r.pins_oe;
  assign crs_dv_o = r.crs_dv;
  assign crs_dv_oe_o = r.pins_oe;
  assign rxer_o = r.rxer;
  assign rxer_oe_o = r.pins_oe;
  assign txd1_o = r.txd1;
  assign txd1_oe_o = r.txd1_oe;
  assign interrupt_out_o = 1'b0; // Open-drain: only ever drives low
  assign interrupt_out_oe_o = r.int_drv;
  assign phy_address_strap_o = r.phyad;
  assign wake_output_enable_strap_o = r.wake_en;
  assign ref_50m_mode_o = r.ref50;

  // Checks on the pin timing, straps and interrupt path
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_rxd_edge;
    $changed(rxd_o) |-> $past(rise) && $past(run);
  endproperty
  a_rxd_edge: assert property (p_rxd_edge) else $error("RXD moved off an edge");

  property p_rx_dibit;
    run && rise && rx_if.rd_valid |=> crs_dv_o && rxd_o == $past(rx_if.rd_data[1:0]);
  endproperty
  a_rx_dibit: assert property (p_rx_dibit) else $error("Dibit not presented");

  property p_crs_idle;
    run && rise && !rx_if.rd_valid |=> !crs_dv_o && !rxer_o;
  endproperty
  a_crs_idle: assert property (p_crs_idle) else $error("CRS_DV high with no data");

  property p_tx_take;
    run && rise && pin_s[PIN_TXEN] |=>
      tx_valid_o && tx_dibit_o == {$past(pin_s[PIN_TXD1]), $past(pin_s[PIN_TXD0])};
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("Transmit dibit lost");

  property p_tx_edge;
    tx_valid_o |-> $past(rise) && !$past(tx_valid_o);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("Transmit sample off edge");

  property p_strap_inputs;
    r.phase == PH_STRAP |-> !crs_dv_oe_o && !rxer_oe_o && !rxd_oe_o && !ref_clk_oe_o;
  endproperty
  a_strap_inputs: assert property (p_strap_inputs) else $error("Strap pin driven");

  property p_strap_addr;
    r.phase == PH_STRAP && r.wait_cnt == STRAP_LAST |=>
      phy_address_strap_o == {2{$past(pin_s[PIN_CRS])}} && crs_dv_oe_o;
  endproperty
  a_strap_addr: assert property (p_strap_addr) else $error("Address strap wrong");

  property p_strap_wake;
    r.phase == PH_STRAP && r.wait_cnt == STRAP_LAST |=>
      wake_output_enable_strap_o == $past(pin_s[PIN_RXER]);
  endproperty
  a_strap_wake: assert property (p_strap_wake) else $error("Wake strap wrong");

  property p_ref_mode;
    run && $past(run) && $stable(r.ref50) |-> ref_clk_oe_o == !r.ref50;
  endproperty
  a_ref_mode: assert property (p_ref_mode) else $error("Reference pin mode wrong");

  property p_int_pol;
    run && !wake_path |=> interrupt_out_oe_o == ($past(active) ^ $past(r.int_pol));
  endproperty
  a_int_pol: assert property (p_int_pol) else $error("Interrupt polarity wrong");

  property p_set_wins;
    rd_ics && int_event_i[0] |=> r.int_stat[0] ##1 (r.int_stat[0] || $past(rd_ics));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Event lost on clear");

  property p_wake;
    run && wake_path && r.wake_pend |=> interrupt_out_oe_o && !interrupt_out_o;
  endproperty
  a_wake: assert property (p_wake) else $error("Wake event not signalled");

  property p_nand;
    run && pin_s[PIN_NAND] |=>
      txd1_oe_o && txd1_o == !($past(pin_s[PIN_TXEN]) && $past(pin_s[PIN_TXD0]));
  endproperty
  a_nand: assert property (p_nand) else $error("NAND tree output wrong");

  // Main scenarios
  c_rx_dibit: cover property (run && rise && rx_if.rd_valid ##1 crs_dv_o);
  c_tx_dibit: cover property (tx_valid_o);
  c_rx_full: cover property (!rx_ready_o);
  c_int_pin: cover property (interrupt_out_oe_o);
endmodule
`default_nettype wire

// ==== prm_mac_model.sv ====
// Behavioural RMII MAC with board pulls, strap resistors and pin resolution
`default_nettype none
module prm_mac_model #(
  parameter logic STRAP_CRS = 1'b1,
  parameter logic STRAP_RXER = 1'b1
) (
  // Mode and device pin drivers
  input wire logic ref50_i,
  input wire logic ref_clk_i,
  input wire logic ref_clk_oe_i,
  input wire logic [1:0] rxd_i,
  input wire logic rxd_oe_i,
  input wire logic crs_dv_i,
  input wire logic crs_dv_oe_i,
  input wire logic rxer_i,
  input wire logic rxer_oe_i,
  input wire logic txd1_i,
  input wire logic txd1_oe_i,
  input wire logic int_oe_i,
  // Resolved pin levels
  output logic ext_clk_o,
  output logic crs_dv_pin_o,
  output logic rxer_pin_o,
  output logic txen_o,
  output logic txd0_o,
  output logic txd1_pin_o,
  output logic int_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_clk = 1'b0;
  logic txen = 1'b0;
  logic [1:0] txd = 2'b00;
  logic ref_pin;
  logic [2:0] rx_got[$];
  // Oscillator runs free, it is not gated by frames
  always #160 ext_clk = ~ext_clk;
  // Strap resistors win while the device pins are still inputs
  assign crs_dv_pin_o = crs_dv_oe_i ? crs_dv_i : STRAP_CRS;
  assign rxer_pin_o = rxer_oe_i ? rxer_i : STRAP_RXER;
  // Undriven reference pin sits at its pull-down
  assign ref_pin = ref50_i ? ext_clk : (ref_clk_oe_i & ref_clk_i);
  assign txd1_pin_o = txd1_oe_i ? txd1_i : txd[1];
  // Open-drain line with board pull-up
  assign int_pin_o = int_oe_i ? 1'b0 : 1'b1;
  assign ext_clk_o = ext_clk;
  assign txen_o = txen;
  assign txd0_o = txd[0];
  // Capture mid-period so the device has a full half period to settle
  always @(negedge ref_pin) begin
    if (crs_dv_pin_o) rx_got.push_back({rxer_pin_o, rxd_oe_i ? rxd_i : 2'b01});
  end
  // One transmit period, launched at the falling reference edge
  task automatic send(input logic en, input logic [1:0] d);
    @(negedge ref_pin);
    // Non-blocking: the falling reference edge can share a system clock edge
    txen <= en;
    txd <= d;
  endtask
endmodule
`default_nettype wire

// ==== prm_rmii_pins_tb.sv ====
// Self-checking bench for the RMII pin block
`default_nettype none
module prm_rmii_pins_tb;
  import prm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, rx_valid_i = 1'b0, rx_err_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, wake_i = 1'b0, nand_tree_mode_i = 1'b0;
  logic [1:0] rx_dibit_i = 2'b00;
  logic [7:0] int_event_i = 8'h00;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic rx_ready_o, tx_valid_o, ref_clk_o, ref_clk_oe_o, rxd_oe_o, crs_dv_o, crs_dv_oe_o;
  logic rxer_o, rxer_oe_o, txd1_o, txd1_oe_o, int_o, int_oe, wake_strap, ref50;
  logic [1:0] tx_dibit_o, rxd_o, addr_strap;
  logic [15:0] reg_rdata_o;
  logic ext_clk, crs_pin, rxer_pin, txen, txd0, txd1_pin, int_pin;
  int failures = 0;
  int checks_done = 0;
  int seed = 58;
  logic [1:0] tx_exp[$], tx_got[$];
  logic [2:0] rx_exp[$];

  always #20 sys_clk_i = ~sys_clk_i;

  prm_rmii_pins dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .rx_valid_i(rx_valid_i), .rx_dibit_i(rx_dibit_i), .rx_err_i(rx_err_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_dibit_o(tx_dibit_o),
    .int_event_i(int_event_i), .wake_on_lan_event_i(wake_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .external_clock_in_i(ext_clk), .ref_clk_o(ref_clk_o), .ref_clk_oe_o(ref_clk_oe_o),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .crs_dv_i(crs_pin), .crs_dv_o(crs_dv_o),
    .crs_dv_oe_o(crs_dv_oe_o), .rxer_i(rxer_pin), .rxer_o(rxer_o), .rxer_oe_o(rxer_oe_o),
    .txen_i(txen), .txd0_i(txd0), .txd1_i(txd1_pin), .txd1_o(txd1_o),
    .txd1_oe_o(txd1_oe_o), .interrupt_out_i(int_pin), .interrupt_out_o(int_o),
    .interrupt_out_oe_o(int_oe), .nand_tree_mode_i(nand_tree_mode_i),
    .phy_address_strap_o(addr_strap), .wake_output_enable_strap_o(wake_strap),
    .ref_50m_mode_o(ref50)
  );

  prm_mac_model mdl (
    .ref50_i(ref50), .ref_clk_i(ref_clk_o), .ref_clk_oe_i(ref_clk_oe_o),
    .rxd_i(rxd_o), .rxd_oe_i(rxd_oe_o), .crs_dv_i(crs_dv_o), .crs_dv_oe_i(crs_dv_oe_o),
    .rxer_i(rxer_o), .rxer_oe_i(rxer_oe_o), .txd1_i(txd1_o), .txd1_oe_i(txd1_oe_o),
    .int_oe_i(int_oe), .ext_clk_o(ext_clk), .crs_dv_pin_o(crs_pin), .rxer_pin_o(rxer_pin),
    .txen_o(txen), .txd0_o(txd0), .txd1_pin_o(txd1_pin), .int_pin_o(int_pin)
  );

  // Transmit pulses last one cycle, so look once per cycle mid-period
  always @(negedge sys_clk_i) begin
    if (tx_valid_o === 1'b1) tx_got.push_back(tx_dibit_o);
  end

  function automatic logic int_exp(input logic [7:0] st, input logic [7:0] en, input logic pol);
    return (|(st & en)) ^ pol;
  endfunction

  function automatic logic nand2(input logic a, input logic b);
    return ~(a & b);
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask

  // Read data stands for one cycle only, so grab it at the next falling edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask

  task automatic evt(input logic [7:0] e, input logic w);
    @(negedge sys_clk_i);
    int_event_i = e;
    wake_i = w;
    @(negedge sys_clk_i);
    int_event_i = 8'h00;
    wake_i = 1'b0;
    cyc(2);
  endtask

  task automatic tx_run(input int n);
    logic [1:0] d;
    tx_got.delete();
    tx_exp.delete();
    for (int i = 0; i < n; i++) begin
      d = 2'($random(seed));
      tx_exp.push_back(d);
      mdl.send(1'b1, d);
    end
    mdl.send(1'b0, 2'b00);
    cyc(20);
    chk("tx_count", 16'(tx_got.size()), 16'(n));
    foreach (tx_exp[i]) chk("tx_dibit", 16'(tx_got[i]), 16'(tx_exp[i]));
  endtask

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    failures++;
    give_verdict();
  end

  initial begin
    logic [15:0] d;
    logic [2:0] w;
    logic full;
    time t;
    cyc(5);
    chk("rst_mode", 16'(ref50), 16'h0000);
    chk("rst_crs_oe", 16'(crs_dv_oe_o), 16'h0000);
    reset_n_i = 1'b1;
    cyc(2);
    chk("strap_crs_oe", 16'(crs_dv_oe_o), 16'h0000);
    cyc(5);
    chk("pin_oe", 16'({crs_dv_oe_o, rxer_oe_o, rxd_oe_o}), 16'h0007);
    chk("addr_strap", 16'(addr_strap), 16'h0003);
    chk("wake_strap", 16'(wake_strap), 16'h0001);
    rd(REG_CTRL_TWO, d);
    chk("ctrl2_rst", d, 16'h0000);
    rd(5'h05, d);
    chk("unmapped", d, 16'h0000);
    chk("ref_oe", 16'(ref_clk_oe_o), 16'h0001);
    @(posedge ref_clk_o);
    t = $time;
    @(posedge ref_clk_o);
    chk("ref_period", 16'($time - t), 16'(2 * REF_HALF_CYC * SYS_PERIOD_NS));
    // Masked, then enabled event, read-to-clear, then inverted polarity
    wr(REG_INT_CS, 16'h0500);
    evt(8'h02, 1'b0);
    chk("int_masked", 16'(int_oe), 16'(int_exp(8'h02, 8'h05, 1'b0)));
    evt(8'h04, 1'b0);
    chk("int_set", 16'(int_oe), 16'(int_exp(8'h06, 8'h05, 1'b0)));
    chk("int_pin", 16'({int_pin, int_o}), 16'h0000);
    rd(REG_INT_CS, d);
    chk("int_cs", d, 16'h0506);
    cyc(1);
    chk("int_clr", 16'(int_oe), 16'h0000);
    rd(REG_INT_CS, d);
    chk("int_cs_clr", d, 16'h0500);
    wr(REG_CTRL_TWO, 16'h0200);
    cyc(1);
    chk("int_pol", 16'(int_oe), 16'(int_exp(8'h00, 8'h05, 1'b1)));
    evt(8'h01, 1'b0);
    chk("int_pol_set", 16'(int_oe), 16'(int_exp(8'h01, 8'h05, 1'b1)));
    // Event held across a clearing read: the new event must survive
    int_event_i = 8'h01;
    rd(REG_INT_CS, d);
    int_event_i = 8'h00;
    chk("int_cs_race", d, 16'h0501);
    rd(REG_INT_CS, d);
    chk("int_set_wins", d, 16'h0501);
    rd(REG_INT_CS, d);
    chk("int_cs_empty", d, 16'h0500);
    // Wake-event option on the shared pin
    wr(REG_CTRL_TWO, 16'h0008);
    evt(8'h00, 1'b1);
    chk("wake_pin", 16'({int_oe, int_pin}), 16'h0002);
    rd(REG_CTRL_TWO, d);
    chk("wake_pend", d, 16'h0009);
    cyc(1);
    chk("wake_clr", 16'(int_oe), 16'h0000);
    wr(REG_CTRL_TWO, 16'h0000);
    // Fill the buffer until refused while the line drains slowly
    mdl.rx_got.delete();
    full = 1'b0;
    for (int i = 0; i < 40 && !full; i++) begin
      @(negedge sys_clk_i);
      w = 3'($random(seed));
      {rx_err_i, rx_dibit_i} = w;
      rx_valid_i = (rx_ready_o === 1'b1);
      if (rx_valid_i) rx_exp.push_back(w);
      else full = 1'b1;
    end
    @(negedge sys_clk_i);
    rx_valid_i = 1'b0;
    chk("rx_full", 16'({full, rx_exp.size() >= 16}), 16'h0003);
    for (int k = 0; k < 600 && mdl.rx_got.size() < rx_exp.size(); k++) cyc(1);
    chk("rx_count", 16'(mdl.rx_got.size()), 16'(rx_exp.size()));
    foreach (rx_exp[i]) chk("rx_word", 16'(mdl.rx_got[i]), 16'(rx_exp[i]));
    cyc(20);
    chk("rx_idle_crs", 16'(crs_dv_o), 16'h0000);
    tx_run(12);
    // Switch to the external reference and transmit again
    wr(REG_CTRL_TWO, 16'h0080);
    cyc(2);
    chk("mode50", 16'({ref50, ref_clk_oe_o}), 16'h0002);
    tx_run(10);
    // NAND tree: every input combination
    nand_tree_mode_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      mdl.send(i[1], {1'b0, i[0]});
      cyc(6);
      chk("nand", 16'({txd1_oe_o, txd1_o}), 16'({1'b1, nand2(i[1], i[0])}));
    end
    nand_tree_mode_i = 1'b0;
    cyc(4);
    chk("nand_off", 16'(txd1_oe_o), 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
